// *** hw/edge_sync.v ***
`timescale 1ns/1ps

// Two-flop synchroniser with a falling-edge strobe on the safe side
module edge_sync #(
	parameter WIDTH = 1
) (
	// Clock and reset
	input  wire             clk_in,
	input  wire             sys_rst_in,
	// Raw input and synchronised results
	input  wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out,
	output wire [WIDTH-1:0] fall_out
);

	reg [WIDTH-1:0] meta_reg;
	reg [WIDTH-1:0] sync_reg;
	reg [WIDTH-1:0] prev_reg;

	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			meta_reg <= {WIDTH{1'b0}};
			sync_reg <= {WIDTH{1'b0}};
			prev_reg <= {WIDTH{1'b0}};
		end else begin
			meta_reg <= async_in;
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	assign sync_out = sync_reg;
	assign fall_out = prev_reg & ~sync_reg;

endmodule // edge_sync

// *** hw/valley_core_defines.vh ***
`ifndef VALLEY_CORE_DEFINES_VH
`define VALLEY_CORE_DEFINES_VH

// Clock rate in kHz
`define CLK_KHZ          25000
// Soft-start total time (ms) and step count
`define SS_TIME_MS       12
`define SS_STEPS         4
// Evaluation period of the valley counter (ms)
`define EVAL_TIME_MS     48
// Valley counter limits and start value
`define VALLEY_MIN       3'h1
`define VALLEY_MAX       3'h7
// Zero-crossing counter limits
`define ZC_MIN           3'h0
`define ZC_MAX           3'h7
// Current-limit step codes: 0 lowest, 3 final level
`define ILIM_LOWEST      2'h0
`define ILIM_FINAL       2'h3
// Ringing suppression, max off time, overvoltage blanking (us)
`define RING_SUPP_US     5
`define MAX_OFF_US       50
`define OVP_BLANK_US     2

`endif

// *** hw/valley_select_softstart_logic.v ***
`timescale 1ns/1ps
`include "valley_core_defines.vh"

// Notes on behaviour
// - Supply above turn-on level stops startup charging and starts soft-start.
// - Soft-start lasts a preset total time split into equal steps.
// - Current limit steps up from lowest to final level during soft-start.
// - Turn-on from valley logic; turn-off from analog current comparison.
// - Valley counter holds the valley number where switch turns on.
// - Feedback compared to three thresholds; counter updated once per period.
// - Feedback always below low threshold: count up, saturate at seven.
// - Above low but never above high: counter holds.
// - Above high but never reset threshold: count down, saturate at one.
// - Above reset threshold at any time: counter forced to one.
// - Counter stays within one to seven; out-of-range steps ignored.
// - Counter starts at one after start-up.
// - Low and high thresholds chosen by line level, immune to foldback.
// - Zero-crossing counter ranges zero to seven, holding at seven.
// - After turn-off, count each falling crossing of the valley threshold.
// - Zero-crossing counter cleared whenever the gate goes high.
// - Overvoltage on valley input during off-time latches off after blanking.
// - After ringing suppression, turn on when count reaches valley value.
// - No turn-on during ringing suppression after turn-off.
// - Off for maximum off time: turn on regardless of counters.
module valley_select_softstart_logic #(
	parameter SS_CYCLES   = (`SS_TIME_MS * `CLK_KHZ) / `SS_STEPS,
	parameter EVAL_CYCLES = `EVAL_TIME_MS * `CLK_KHZ,
	parameter CNT_W       = 21
) (
	// Clock and reset
	input  wire       clk_in,
	input  wire       sys_rst_in,
	// Analog comparator results
	input  wire       supply_on_in,
	input  wire       line_high_in,
	input  wire       fb_low_lo_in,
	input  wire       fb_low_hi_in,
	input  wire       fb_high_lo_in,
	input  wire       fb_high_hi_in,
	input  wire       fb_reset_in,
	input  wire       valley_sense_in,
	input  wire       valley_ovp_in,
	input  wire       cs_trip_in,
	// Control outputs
	output reg        startup_cell_en_out,
	output reg        gate_on_out,
	output reg        latched_off_out,
	output reg  [1:0] ilim_step_out,
	output reg  [2:0] valley_count_out,
	output reg  [2:0] zc_count_out
);

	// Cycle counts worked out at full integer width, then cut to CNT_W
	localparam integer RING_I    = (`RING_SUPP_US * `CLK_KHZ + 999) / 1000;
	localparam integer MOFF_I    = (`MAX_OFF_US * `CLK_KHZ) / 1000;
	localparam integer OVP_I     = (`OVP_BLANK_US * `CLK_KHZ + 999) / 1000;
	localparam integer SS_I      = SS_CYCLES - 1;
	localparam integer EVAL_I    = EVAL_CYCLES - 1;
	localparam [CNT_W-1:0] RING_CYC  = RING_I[CNT_W-1:0];
	localparam [CNT_W-1:0] MOFF_CYC  = MOFF_I[CNT_W-1:0];
	localparam [CNT_W-1:0] OVP_CYC   = OVP_I[CNT_W-1:0];
	localparam [CNT_W-1:0] SS_LAST   = SS_I[CNT_W-1:0];
	localparam [CNT_W-1:0] EVAL_LAST = EVAL_I[CNT_W-1:0];

	// One-hot states of the power switch sequence
	localparam [3:0] ST_WAIT = 4'h1;
	localparam [3:0] ST_ON   = 4'h2;
	localparam [3:0] ST_OFF  = 4'h4;
	localparam [3:0] ST_LOCK = 4'h8;

	// Synchronised comparator bank
	wire [9:0] raw_w = {cs_trip_in, valley_ovp_in, valley_sense_in,
		fb_reset_in, fb_high_hi_in, fb_high_lo_in, fb_low_hi_in,
		fb_low_lo_in, line_high_in, supply_on_in};
	wire [9:0] syn_w;
	wire [9:0] fall_w;

	edge_sync #(
		.WIDTH (10)
	) u_sync (
		.clk_in     (clk_in),
		.sys_rst_in (sys_rst_in),
		.async_in   (raw_w),
		.sync_out   (syn_w),
		.fall_out   (fall_w)
	);

	wire supply_on = syn_w[0];
	wire line_high = syn_w[1];
	wire fb_rst    = syn_w[6];
	wire zc_fall   = fall_w[7];
	wire ovp_hi    = syn_w[8];
	wire cs_trip   = syn_w[9];

	// Line-selected thresholds
	wire fb_low  = line_high ? syn_w[3] : syn_w[2];
	wire fb_high = line_high ? syn_w[5] : syn_w[4];

	function [2:0] sat_step;
		input [2:0] val;
		input       up;
		begin
			if (up)
				sat_step = (val == `VALLEY_MAX) ? val : val + 3'h1;
			else
				sat_step = (val == `VALLEY_MIN) ? val : val - 3'h1;
		end
	endfunction

	function [CNT_W-1:0] inc_cnt;
		input [CNT_W-1:0] val;
		begin
			inc_cnt = val + {{(CNT_W-1){1'b0}}, 1'b1};
		end
	endfunction

	reg [3:0]       state_reg,  state_next;
	reg [CNT_W-1:0] ss_cnt_reg, ss_cnt_next;
	reg [1:0]       ss_step_reg, ss_step_next;
	reg [CNT_W-1:0] eval_reg,   eval_next;
	reg             seen_low_reg, seen_low_next;
	reg             seen_high_reg, seen_high_next;
	reg             seen_rst_reg, seen_rst_next;
	reg [2:0]       valley_reg, valley_next;
	reg [2:0]       zc_reg,     zc_next;
	reg [CNT_W-1:0] off_cnt_reg, off_cnt_next;
	reg [CNT_W-1:0] ovp_cnt_reg, ovp_cnt_next;
	reg             running;
	reg             turn_on;

	always @* begin
		state_next     = state_reg;
		ss_cnt_next    = ss_cnt_reg;
		ss_step_next   = ss_step_reg;
		eval_next      = eval_reg;
		seen_low_next  = seen_low_reg;
		seen_high_next = seen_high_reg;
		seen_rst_next  = seen_rst_reg;
		valley_next    = valley_reg;
		zc_next        = zc_reg;
		off_cnt_next   = off_cnt_reg;
		ovp_cnt_next   = ovp_cnt_reg;
		running        = (state_reg == ST_ON) || (state_reg == ST_OFF);
		turn_on        = 1'b0;

		// Soft-start stepping
		if (running && ss_step_reg != `ILIM_FINAL) begin
			if (ss_cnt_reg == SS_LAST) begin
				ss_cnt_next  = {CNT_W{1'b0}};
				ss_step_next = ss_step_reg + 2'h1;
			end else begin
				ss_cnt_next = inc_cnt(ss_cnt_reg);
			end
		end

		// Evaluation period and sticky flags
		if (running) begin
			seen_low_next  = seen_low_reg | fb_low;
			seen_high_next = seen_high_reg | fb_high;
			seen_rst_next  = seen_rst_reg | fb_rst;
			if (eval_reg == EVAL_LAST) begin
				eval_next      = {CNT_W{1'b0}};
				seen_low_next  = 1'b0;
				seen_high_next = 1'b0;
				seen_rst_next  = 1'b0;
				if (seen_rst_reg | fb_rst)
					valley_next = `VALLEY_MIN;
				else if (seen_high_reg | fb_high)
					valley_next = sat_step(valley_reg, 1'b0);
				else if (seen_low_reg | fb_low)
					valley_next = valley_reg;
				else
					valley_next = sat_step(valley_reg, 1'b1);
			end else begin
				eval_next = inc_cnt(eval_reg);
			end
		end

		case (state_reg)
			ST_WAIT: begin
				if (supply_on) begin
					state_next   = ST_ON;
					turn_on      = 1'b1;
					valley_next  = `VALLEY_MIN;
					ss_cnt_next  = {CNT_W{1'b0}};
					ss_step_next = `ILIM_LOWEST;
					eval_next    = {CNT_W{1'b0}};
				end
			end
			ST_ON: begin
				if (cs_trip) begin
					state_next   = ST_OFF;
					off_cnt_next = {CNT_W{1'b0}};
					ovp_cnt_next = {CNT_W{1'b0}};
				end
			end
			ST_OFF: begin
				if (off_cnt_reg != MOFF_CYC)
					off_cnt_next = inc_cnt(off_cnt_reg);
				if (zc_fall && zc_reg != `ZC_MAX)
					zc_next = zc_reg + 3'h1;
				if (ovp_hi) begin
					ovp_cnt_next = inc_cnt(ovp_cnt_reg);
					if (ovp_cnt_reg == OVP_CYC)
						state_next = ST_LOCK;
				end else begin
					ovp_cnt_next = {CNT_W{1'b0}};
				end
				if (state_next != ST_LOCK) begin
					if (off_cnt_reg == MOFF_CYC) begin
						turn_on = 1'b1;
					end else if (off_cnt_reg >= RING_CYC &&
						zc_reg >= valley_reg) begin
						turn_on = 1'b1;
					end
					if (turn_on)
						state_next = ST_ON;
				end
			end
			ST_LOCK: begin
				state_next = ST_LOCK;
			end
			default: begin
				state_next = ST_WAIT;
			end
		endcase

		if (turn_on)
			zc_next = `ZC_MIN;
	end

	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			state_reg           <= ST_WAIT;
			ss_cnt_reg          <= {CNT_W{1'b0}};
			ss_step_reg         <= `ILIM_LOWEST;
			eval_reg            <= {CNT_W{1'b0}};
			seen_low_reg        <= 1'b0;
			seen_high_reg       <= 1'b0;
			seen_rst_reg        <= 1'b0;
			valley_reg          <= `VALLEY_MIN;
			zc_reg              <= `ZC_MIN;
			off_cnt_reg         <= {CNT_W{1'b0}};
			ovp_cnt_reg         <= {CNT_W{1'b0}};
			startup_cell_en_out <= 1'b1;
			gate_on_out         <= 1'b0;
			latched_off_out     <= 1'b0;
			ilim_step_out       <= `ILIM_LOWEST;
			valley_count_out    <= `VALLEY_MIN;
			zc_count_out        <= `ZC_MIN;
		end else begin
			state_reg           <= state_next;
			ss_cnt_reg          <= ss_cnt_next;
			ss_step_reg         <= ss_step_next;
			eval_reg            <= eval_next;
			seen_low_reg        <= seen_low_next;
			seen_high_reg       <= seen_high_next;
			seen_rst_reg        <= seen_rst_next;
			valley_reg          <= valley_next;
			zc_reg              <= zc_next;
			off_cnt_reg         <= off_cnt_next;
			ovp_cnt_reg         <= ovp_cnt_next;
			startup_cell_en_out <= (state_next == ST_WAIT);
			gate_on_out         <= (state_next == ST_ON);
			latched_off_out     <= (state_next == ST_LOCK);
			ilim_step_out       <= ss_step_next;
			valley_count_out    <= valley_next;
			zc_count_out        <= zc_next;
		end
	end

endmodule // valley_select_softstart_logic

// *** test/flyback_stage_model.sv ***
`timescale 1ns/1ps
module flyback_stage_model (
	// Clock
	input  wire       clk_in,
	// Gate drive and ringing length
	input  wire       gate_on_in,
	input  wire [3:0] rings_in,
	// Comparator results
	output reg        cs_trip_out,
	output reg        sense_out
);
	reg       gate_reg = 1'b0;
	reg [7:0] cnt_reg  = 8'h00;
	initial begin
		cs_trip_out = 1'b0;
		sense_out = 1'b0;
	end
	// Cycles spent in present gate state, saturating
	always @(posedge clk_in) begin
		gate_reg <= gate_on_in;
		if (gate_on_in != gate_reg)
			cnt_reg <= 8'h00;
		else
			cnt_reg <= cnt_reg + {7'h00, ~&cnt_reg};
		cs_trip_out <= gate_on_in && cnt_reg >= 8'h0a;
		sense_out <= !gate_on_in && !cnt_reg[2] &&
			cnt_reg[7:3] < rings_in;
	end
endmodule // flyback_stage_model

// *** test/testbench.sv ***
`timescale 1ns/1ps
module testbench;
	reg        clk_in = 1'b0, sys_rst_in = 1'b1, supply_on_in = 1'b0;
	reg        line_high_in = 1'b0, fb_reset_in = 1'b0, valley_ovp_in = 1'b0;
	reg        fb_low_lo_in = 1'b0, fb_low_hi_in = 1'b0;
	reg        fb_high_lo_in = 1'b0, fb_high_hi_in = 1'b0;
	reg  [3:0] rings = 4'h9;
	reg  [2:0] v;
	wire       cs_trip, sense, start_en, gate, latched;
	wire [1:0] ilim;
	wire [2:0] valley, zc;
	integer    error_cnt = 0, num_checks = 0, n, i;

	valley_select_softstart_logic #(.SS_CYCLES(20), .EVAL_CYCLES(200)) uut (
		.clk_in(clk_in), .sys_rst_in(sys_rst_in), .supply_on_in(supply_on_in),
		.line_high_in(line_high_in), .fb_low_lo_in(fb_low_lo_in),
		.fb_low_hi_in(fb_low_hi_in), .fb_high_lo_in(fb_high_lo_in),
		.fb_high_hi_in(fb_high_hi_in), .fb_reset_in(fb_reset_in),
		.valley_sense_in(sense), .valley_ovp_in(valley_ovp_in),
		.cs_trip_in(cs_trip), .startup_cell_en_out(start_en),
		.gate_on_out(gate), .latched_off_out(latched), .ilim_step_out(ilim),
		.valley_count_out(valley), .zc_count_out(zc));
	flyback_stage_model stage (.clk_in(clk_in), .gate_on_in(gate),
		.rings_in(rings), .cs_trip_out(cs_trip), .sense_out(sense));

	initial begin
		forever #20 clk_in = ~clk_in;
	end

	task chk(input string name, input [2:0] exp, input [2:0] got);
		if (got !== exp) begin
			error_cnt = error_cnt + 1;
			$display("[ERR] %s expected %0d seen %0d", name, exp, got);
		end
		num_checks = num_checks + 1;
	endtask
	task cyc(input integer c);
		repeat (c) @(negedge clk_in);
	endtask
	task wait_gate(input val);
		n = 0;
		while (gate !== val && n < 2000) begin
			@(negedge clk_in);
			n = n + 1;
		end
	endtask
	task step(input [2:0] exp);
		v = valley;
		for (i = 0; valley === v && i < 400; i = i + 1) cyc(1);
		chk("valley", exp, valley);
	endtask
	task conclude;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task t_start;
		chk("startup cell", 3'h1, {2'h0, start_en});
		@(posedge clk_in) supply_on_in <= 1'b1;
		cyc(2);
		chk("sync delay", 3'h0, {2'h0, gate});
		wait_gate(1'b1);
		chk("startup cell", 3'h0, {2'h0, start_en});
		chk("valley", 3'h1, valley);
		chk("ilim", 3'h0, {1'b0, ilim});
		cyc(50);
		chk("ilim", 3'h2, {1'b0, ilim});
		cyc(50);
		chk("ilim", 3'h3, {1'b0, ilim});
		$display("start done");
	endtask
	task t_counter;
		for (int k = 2; k < 8; k++) step(k[2:0]);
		cyc(450);
		chk("valley top", 3'h7, valley);
		@(posedge clk_in) line_high_in <= 1'b1;
		fb_low_hi_in <= 1'b1;
		fb_high_hi_in <= 1'b1;
		step(3'h6);
		step(3'h5);
		@(posedge clk_in) line_high_in <= 1'b0;
		fb_low_lo_in <= 1'b1;
		step(3'h4);
		cyc(450);
		chk("valley hold", 3'h4, valley);
		@(posedge clk_in) fb_high_lo_in <= 1'b1;
		step(3'h3);
		@(posedge clk_in) fb_high_lo_in <= 1'b0;
		step(3'h2);
		@(posedge clk_in) fb_reset_in <= 1'b1;
		step(3'h1);
		@(posedge clk_in) fb_reset_in <= 1'b0;
		$display("counter done");
	endtask
	task t_valley;
		wait_gate(1'b1);
		wait_gate(1'b0);
		cyc(110);
		chk("zc top", 3'h7, zc);
		wait_gate(1'b1);
		chk("on delay", 3'h1, {2'h0, n > 9 && n < 21});
		chk("zc clear", 3'h0, zc);
		@(posedge clk_in) rings <= 4'h0;
		wait_gate(1'b0);
		wait_gate(1'b1);
		chk("max off", 3'h1, {2'h0, n > 1240 && n < 1260});
		@(posedge clk_in) valley_ovp_in <= 1'b1;
		cyc(100);
		chk("latched", 3'h1, {2'h0, latched});
		@(posedge clk_in) valley_ovp_in <= 1'b0;
		cyc(300);
		chk("gate", 3'h0, {2'h0, gate});
		$display("valley done");
	endtask

	initial begin
		#480000;
		error_cnt = error_cnt + 1;
		conclude;
	end
	initial begin
		repeat (20) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		t_start;
		t_counter;
		t_valley;
		conclude;
	end
endmodule // testbench

bind valley_select_softstart_logic valley_core_asserts chk_u (.clk_in,
	.sys_rst_in, .startup_cell_en_out, .gate_on_out, .latched_off_out,
	.ilim_step_out, .valley_count_out, .zc_count_out);

// *** test/valley_core_asserts.sv ***
`timescale 1ns/1ps
module valley_core_asserts (
	// Clock and reset
	input wire       clk_in,
	input wire       sys_rst_in,
	// Watched outputs
	input wire       startup_cell_en_out,
	input wire       gate_on_out,
	input wire       latched_off_out,
	input wire [1:0] ilim_step_out,
	input wire [2:0] valley_count_out,
	input wire [2:0] zc_count_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	reset_vals_a: assert property ($fell(sys_rst_in) |->
		valley_count_out == 3'h1 && zc_count_out == 3'h0 && !gate_on_out)
		else $error("bad values after reset");
	valley_range_a: assert property (valley_count_out >= 3'h1)
		else $error("valley count below one");
	start_cell_a: assert property (gate_on_out |->
		!startup_cell_en_out)
		else $error("startup path on while switching");
	zc_clear_a: assert property ($rose(gate_on_out) |->
		zc_count_out == 3'h0)
		else $error("zero count not cleared at turn-on");
	zc_step_a: assert property ($changed(zc_count_out) &&
		zc_count_out != 3'h0 |->
		zc_count_out == $past(zc_count_out) + 3'h1)
		else $error("zero count jumped");
	ilim_rise_a: assert property (ilim_step_out >= $past(ilim_step_out))
		else $error("current limit step fell");
	valley_step_a: assert property ($changed(valley_count_out) |->
		valley_count_out == 3'h1 ||
		valley_count_out == $past(valley_count_out) + 3'h1 ||
		valley_count_out == $past(valley_count_out) - 3'h1)
		else $error("valley count jumped");
	latch_hold_a: assert property (latched_off_out |=>
		latched_off_out && !gate_on_out)
		else $error("latch-off released");
	ring_supp_a: assert property ($fell(gate_on_out) |=> !gate_on_out [*8])
		else $error("turn-on inside suppression");
	cover property (valley_count_out == 3'h7);
	cover property ($fell(gate_on_out));
	cover property (latched_off_out);
endmodule // valley_core_asserts
